// *** logic/dsau_top.sv ***
`include "dsau_params.svh"

// Overview of operation
// - every data write goes over x write bus
// - bit-reversed update only for x writes
// - dual-operand prefetch uses its own pointer pairs
// - y bus never carries a write
// - accumulator write-back reaches whole data space
// - y path only for dual-operand prefetch, modulo
// - invalid or cross-space read returns zero
// - 16-bit byte effective addresses, 32K words
// - byte read selects lane onto low byte
// - shared word decode, separate byte write lanes
// - post-modify steps one for byte, two word
// - odd word access traps, write suppressed
// - byte load keeps working register high byte
// - near direct 13 bits, move 16 bits
// - stack grows up, post-inc push, pre-dec pop
// - call push clears upper byte of high word
// - exception push puts status low byte up
// - stack limit not reset, bit zero forced
// - push beyond equal limit raises stack error
// - stack address below 0x0800 raises stack error
// - x/y boundary fixed in hardware
module dsau_top import dsau_pkg::*;
(
  // clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  // x access request
  input wire logic I_X_REQ,
  input wire logic I_X_WR,
  input wire logic I_X_BYTE,
  input wire logic I_X_NEAR,
  input wire logic I_X_ACC_WB,
  input wire logic I_MAC,
  input wire logic [3:0] I_X_PTR,
  input wire logic [15:0] I_X_EA,
  input wire logic [15:0] I_X_WDATA,
  input wire logic [15:0] I_WREG_OLD,
  // y prefetch request
  input wire logic I_Y_REQ,
  input wire logic [3:0] I_Y_PTR,
  input wire logic [15:0] I_Y_EA,
  input wire logic I_Y_MOD_EN,
  input wire logic [15:0] I_Y_MOD_START,
  input wire logic [15:0] I_Y_MOD_END,
  // pointer post-modify
  input wire logic [15:0] I_PM_PTR,
  input wire logic I_PM_BYTE,
  input wire logic I_PM_BITREV,
  input wire logic I_PM_WRITE,
  input wire logic [15:0] I_PM_BR_MOD,
  // stack
  input wire logic I_SP_PUSH,
  input wire logic I_SP_POP,
  input wire dsau_push_t I_PUSH_KIND,
  input wire logic [15:0] I_PUSH_DATA,
  input wire logic [7:0] I_SRL,
  input wire logic I_SP_WR,
  input wire logic [15:0] I_SP_WDATA,
  input wire logic I_STACK_LIMIT_REGISTER_WR,
  input wire logic [15:0] I_STACK_LIMIT_REGISTER_WDATA,
  // data memory
  output logic [14:0] O_MEM_X_ADDR,
  output logic O_MEM_X_RE,
  output logic [1:0] O_MEM_X_WE,
  output logic [15:0] O_MEM_X_WDATA,
  input wire logic [15:0] I_MEM_X_RDATA,
  output logic [14:0] O_MEM_Y_ADDR,
  output logic O_MEM_Y_RE,
  input wire logic [15:0] I_MEM_Y_RDATA,
  // results
  output logic [15:0] O_X_RDATA,
  output logic O_X_RVALID,
  output logic [15:0] O_WREG_NEW,
  output logic [15:0] O_Y_RDATA,
  output logic O_Y_RVALID,
  output logic [15:0] O_Y_PTR_NEXT,
  output logic [15:0] O_PM_PTR_NEXT,
  output logic [15:0] O_SP,
  // trap requests
  output logic O_ADDR_ERR_TRAP,
  output logic O_STACK_ERR_TRAP
);

////////////////////////////////////////////////////////////////////////////////

logic [15:0] sp_reg, sp_next;
logic [15:0] stack_limit_register_reg;
logic [15:0] x_rdata_reg, wreg_reg, y_rdata_reg, y_ptr_reg, pm_reg;
logic x_rvalid_reg, y_rvalid_reg, aerr_reg, serr_reg;
wire logic [15:0] x_ea, pop_ea, stk_ea, acc_ea, push_word, x_rfmt, pm_next;
wire logic stk_act, acc_byte, acc_wr, acc_rd, acc_req, misalign;
wire logic impl, x_in_y, xptr_ok, mac_x_bad, x_zero;
wire logic y_in, yptr_ok, y_go, y_zero, stk_ovf, stk_unf;
wire logic [7:0] rbyte;

////////////////////////////////////////////////////////////////////////////////
// x address selection: stack traffic shares the x port

assign x_ea = I_X_NEAR ? {3'h0, I_X_EA[`DSAU_NEAR_W-1:0]} : I_X_EA;
// pop pre-decrements, push uses current word
assign pop_ea = sp_reg - `DSAU_STEP_W;
assign stk_ea = I_SP_POP ? pop_ea : sp_reg;
assign stk_act = I_SP_PUSH | I_SP_POP;
assign acc_ea = stk_act ? stk_ea : x_ea;
assign acc_byte = !stk_act & I_X_BYTE;
assign acc_wr = stk_act ? I_SP_PUSH : (I_X_REQ & I_X_WR);
assign acc_rd = stk_act ? I_SP_POP : (I_X_REQ & !I_X_WR);
assign acc_req = stk_act | I_X_REQ;
assign misalign = acc_req & !acc_byte & acc_ea[0];

////////////////////////////////////////////////////////////////////////////////
// space decode; constants only, so software cannot move the boundary

assign impl = acc_ea < `DSAU_PHYS_END;
assign x_in_y = (acc_ea >= `DSAU_Y_BASE) && impl;
assign xptr_ok = (I_X_PTR == `DSAU_XP_A) || (I_X_PTR == `DSAU_XP_B);
// write-back and stack bypass the dual-operand restriction
assign mac_x_bad = I_MAC & !stk_act & !I_X_ACC_WB & (x_in_y | !xptr_ok);
assign x_zero = !impl | (mac_x_bad & acc_rd);

////////////////////////////////////////////////////////////////////////////////
// x memory port

// high word of a pushed program counter
assign push_word = (I_PUSH_KIND == DSAU_PUSH_CALL) ? {8'h00, I_PUSH_DATA[7:0]} :
                   (I_PUSH_KIND == DSAU_PUSH_EXC) ? {I_SRL, I_PUSH_DATA[7:0]} :
                   I_PUSH_DATA;

// word decode shared by both lanes
assign O_MEM_X_ADDR = acc_ea[15:1];
assign O_MEM_X_RE = acc_rd & !x_zero;
// single write path; byte data mirrored onto both lanes
assign O_MEM_X_WDATA = stk_act ? push_word :
                       (acc_byte ? {I_X_WDATA[7:0], I_X_WDATA[7:0]} : I_X_WDATA);
// misaligned write runs but never lands
assign O_MEM_X_WE = (!acc_wr || !impl || misalign) ? 2'h0 :
                    (!acc_byte ? 2'h3 : (acc_ea[0] ? 2'h2 : 2'h1));

assign rbyte = acc_ea[0] ? I_MEM_X_RDATA[15:8] : I_MEM_X_RDATA[7:0];
assign x_rfmt = x_zero ? `DSAU_ZERO : (acc_byte ? {8'h00, rbyte} : I_MEM_X_RDATA);

////////////////////////////////////////////////////////////////////////////////
// y prefetch port, read only, words only

assign y_go = I_Y_REQ & I_MAC;
assign y_in = (I_Y_EA >= `DSAU_Y_BASE) && (I_Y_EA < `DSAU_PHYS_END);
assign yptr_ok = (I_Y_PTR == `DSAU_YP_A) || (I_Y_PTR == `DSAU_YP_B);
assign y_zero = !y_in | !yptr_ok;
// no write strobe exists on this bus
assign O_MEM_Y_RE = y_go & !y_zero;
assign O_MEM_Y_ADDR = I_Y_EA[15:1];

////////////////////////////////////////////////////////////////////////////////
// pointer post-modify; bit-reverse is a reverse-carry add

wire logic [15:0] ptr_rev, mod_rev, sum_rev, br_sum;
assign sum_rev = ptr_rev + mod_rev;
genvar gi;
generate
  for (gi = 0; gi < 16; gi = gi + 1)
  begin : g_rev
    assign ptr_rev[gi] = I_PM_PTR[15-gi];
    assign mod_rev[gi] = I_PM_BR_MOD[15-gi];
    assign br_sum[gi] = sum_rev[15-gi];
  end
endgenerate
// byte step one, word step two
assign pm_next = (I_PM_BITREV && I_PM_WRITE) ? br_sum :
                 (I_PM_PTR + (I_PM_BYTE ? `DSAU_STEP_B : `DSAU_STEP_W));

////////////////////////////////////////////////////////////////////////////////
// stack checks

// equal is still legal, next push is not
assign stk_ovf = I_SP_PUSH & (sp_reg > stack_limit_register_reg);
assign stk_unf = stk_act & (stk_ea < `DSAU_SFR_END);

// pointer update, direct write wins over push and pop
always_comb
begin
  sp_next = sp_reg;
  if (I_SP_WR)
    sp_next = {I_SP_WDATA[15:1], 1'b0};
  else if (I_SP_PUSH)
    sp_next = sp_reg + `DSAU_STEP_W;
  else if (I_SP_POP)
    sp_next = pop_ea;
end

////////////////////////////////////////////////////////////////////////////////
// registers

always_ff @(posedge I_CLK_SYS)
begin
  if (I_RST)
    sp_reg <= `DSAU_SP_RST;
  else
    sp_reg <= sp_next;
end

// limit has no reset, word aligned
always_ff @(posedge I_CLK_SYS)
begin
  if (I_STACK_LIMIT_REGISTER_WR)
    stack_limit_register_reg <= {I_STACK_LIMIT_REGISTER_WDATA[15:1], 1'b0};
end

always_ff @(posedge I_CLK_SYS)
begin
  if (I_RST)
  begin
    x_rdata_reg <= `DSAU_ZERO;
    wreg_reg <= `DSAU_ZERO;
    x_rvalid_reg <= 1'b0;
  end
  else
  begin
    x_rdata_reg <= x_rfmt;
    // byte load leaves high byte alone
    wreg_reg <= acc_byte ? {I_WREG_OLD[15:8], x_rfmt[7:0]} : x_rfmt;
    x_rvalid_reg <= acc_rd;
  end
end

always_ff @(posedge I_CLK_SYS)
begin
  if (I_RST)
  begin
    y_rdata_reg <= `DSAU_ZERO;
    y_rvalid_reg <= 1'b0;
    y_ptr_reg <= `DSAU_ZERO;
    pm_reg <= `DSAU_ZERO;
  end
  else
  begin
    y_rdata_reg <= y_zero ? `DSAU_ZERO : I_MEM_Y_RDATA;
    y_rvalid_reg <= y_go;
    y_ptr_reg <= (I_Y_MOD_EN && (I_Y_EA == I_Y_MOD_END)) ? I_Y_MOD_START :
                 (I_Y_EA + `DSAU_STEP_W);
    pm_reg <= pm_next;
  end
end

// misalignment raises the address trap, overflow and underflow share the stack trap; only a misaligned write is suppressed
always_ff @(posedge I_CLK_SYS)
begin
  if (I_RST)
  begin
    aerr_reg <= 1'b0;
    serr_reg <= 1'b0;
  end
  else
  begin
    aerr_reg <= misalign;
    serr_reg <= stk_ovf | stk_unf;
  end
end

assign O_X_RDATA = x_rdata_reg;
assign O_X_RVALID = x_rvalid_reg;
assign O_WREG_NEW = wreg_reg;
assign O_Y_RDATA = y_rdata_reg;
assign O_Y_RVALID = y_rvalid_reg;
assign O_Y_PTR_NEXT = y_ptr_reg;
assign O_PM_PTR_NEXT = pm_reg;
assign O_SP = sp_reg;
assign O_ADDR_ERR_TRAP = aerr_reg;
assign O_STACK_ERR_TRAP = serr_reg;

////////////////////////////////////////////////////////////////////////////////
// checks

default clocking cb @(posedge I_CLK_SYS); endclocking
default disable iff (I_RST);

AST_WR_X_ONLY: assert property (O_MEM_X_WE != 2'h0 |-> I_SP_PUSH || (I_X_REQ && I_X_WR))
  else $error("write without a write request");
AST_Y_PTR: assert property (O_MEM_Y_RE |-> I_MAC && I_Y_PTR[3:1] == 3'h5)
  else $error("y read with wrong pointer");
AST_MIS_WR: assert property (acc_wr && misalign |-> O_MEM_X_WE == 2'h0 ##1 O_ADDR_ERR_TRAP)
  else $error("misaligned write not suppressed");
AST_ZERO_RET: assert property (I_MAC && I_X_REQ && !I_X_WR && !I_X_ACC_WB
  && !stk_act && x_in_y |=> O_X_RDATA == 16'h0000)
  else $error("cross-space read not zero");
AST_UNIMPL: assert property (I_X_REQ && !I_X_WR && !stk_act && !impl
  |=> O_X_RDATA == 16'h0000)
  else $error("unimplemented read not zero");
AST_BYTE_LOW: assert property (I_X_REQ && !I_X_WR && I_X_BYTE && !stk_act
  |=> O_X_RDATA[15:8] == 8'h00 && O_WREG_NEW[15:8] == $past(I_WREG_OLD[15:8]))
  else $error("byte read touched high byte");
AST_BYTE_LANE: assert property (I_X_REQ && I_X_WR && I_X_BYTE && !stk_act && impl
  |-> O_MEM_X_WE == (acc_ea[0] ? 2'h2 : 2'h1))
  else $error("byte write lane wrong");
AST_SP_PUSH: assert property (I_SP_PUSH && !I_SP_WR |=> O_SP == $past(O_SP) + 16'h0002)
  else $error("push step wrong");
AST_SP_POP: assert property (I_SP_POP && !I_SP_WR |=> O_SP == $past(O_SP) - 16'h0002)
  else $error("pop step wrong");
AST_LIMIT_EQ: assert property (I_SP_PUSH && sp_reg == stack_limit_register_reg && sp_reg >= 16'h0800
  |=> !O_STACK_ERR_TRAP)
  else $error("trap on push at limit");
AST_LIMIT_OVER: assert property (I_SP_PUSH && sp_reg > stack_limit_register_reg |=> O_STACK_ERR_TRAP)
  else $error("push beyond limit not trapped");
AST_UNDERFLOW: assert property (I_SP_POP && sp_reg < 16'h0802 |=> O_STACK_ERR_TRAP)
  else $error("underflow not trapped");
AST_PM_STEP: assert property (!I_PM_BITREV |=> O_PM_PTR_NEXT ==
  $past(I_PM_PTR) + ($past(I_PM_BYTE) ? 16'h0001 : 16'h0002))
  else $error("post-modify step wrong");
AST_CALL_ZX: assert property (I_SP_PUSH && I_PUSH_KIND == DSAU_PUSH_CALL
  |-> O_MEM_X_WDATA[15:8] == 8'h00)
  else $error("call push upper byte not clear");
AST_EXC_SRL: assert property (I_SP_PUSH && I_PUSH_KIND == DSAU_PUSH_EXC
  |-> O_MEM_X_WDATA == {I_SRL, I_PUSH_DATA[7:0]})
  else $error("exception push lacks status byte");
AST_Y_MAC_ONLY: assert property (!I_MAC |-> !O_MEM_Y_RE)
  else $error("y read outside dual-operand");
AST_NEAR: assert property (I_X_REQ && I_X_NEAR && !stk_act
  |-> O_MEM_X_ADDR[14:12] == 3'h0)
  else $error("near access outside near region");

COV_PUSH_POP: cover property (I_SP_PUSH ##1 I_SP_POP);
COV_MISALIGN: cover property (misalign && acc_rd ##1 O_ADDR_ERR_TRAP);
COV_DUAL_READ: cover property (O_MEM_X_RE && O_MEM_Y_RE && I_MAC);
COV_STACK_TRAP: cover property (I_SP_PUSH ##1 O_STACK_ERR_TRAP);

endmodule

// *** logic/dsau_params.svh ***
`ifndef DSAU_PARAMS_SVH
`define DSAU_PARAMS_SVH

// stack pointer value after reset
`define DSAU_SP_RST 16'h0800
// lowest legal stack address, below it is the special register region
`define DSAU_SFR_END 16'h0800
// fixed x/y boundary and end of implemented memory (plain defaults)
`define DSAU_Y_BASE 16'h0900
`define DSAU_PHYS_END 16'h0A00
// near direct field width
`define DSAU_NEAR_W 13
// pointer steps
`define DSAU_STEP_B 16'h0001
`define DSAU_STEP_W 16'h0002
// prefetch pointer register indices
`define DSAU_XP_A 4'h8
`define DSAU_XP_B 4'h9
`define DSAU_YP_A 4'hA
`define DSAU_YP_B 4'hB
// value returned by an invalid read
`define DSAU_ZERO 16'h0000

`endif

// *** logic/dsau_pkg.sv ***
package dsau_pkg;
  // kind of word pushed on the stack, one-hot
  typedef enum logic [2:0]
  {
    DSAU_PUSH_DATA = 3'b001,
    DSAU_PUSH_CALL = 3'b010,
    DSAU_PUSH_EXC = 3'b100
  } dsau_push_t;
endpackage

// *** verif/dsau_mem_model.sv ***
module dsau_mem_model
(
  // clock
  input wire logic i_clk,
  // x port
  input wire logic [14:0] i_x_addr,
  input wire logic i_x_re,
  input wire logic [1:0] i_x_we,
  input wire logic [15:0] i_x_wdata,
  output logic [15:0] o_x_rdata,
  // y port, read only
  input wire logic [14:0] i_y_addr,
  input wire logic i_y_re,
  output logic [15:0] o_y_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:1279];
  logic [15:0] junk;
  // same fill pattern as the bench reference copy
  initial
  begin
    junk = 16'hC3A5;
    for (int i = 0; i < 1280; i++) mem[i] = 16'(i) * 16'h0123 ^ 16'h5A5A;
  end
  // junk moves every cycle so a stale word never passes for data
  always @(posedge i_clk) junk <= junk + 16'h3C5B;
  // word read in the same cycle
  assign o_x_rdata = (i_x_re && i_x_addr < 15'h0500) ? mem[i_x_addr] : junk;
  // y side has no write path
  assign o_y_rdata = (i_y_re && i_y_addr < 15'h0500) ? mem[i_y_addr] : ~junk;
  always @(posedge i_clk)
  begin
    if (i_x_we[0] && i_x_addr < 15'h0500) mem[i_x_addr][7:0] <= i_x_wdata[7:0];
    if (i_x_we[1] && i_x_addr < 15'h0500) mem[i_x_addr][15:8] <= i_x_wdata[15:8];
  end
endmodule

// *** verif/tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dsau_pkg::*;
  logic clk, rst, x_req, x_wr, x_byte, x_near, acc_wb, mac, y_req, y_mod_en;
  logic pm_byte, pm_bitrev, pm_write, sp_push, sp_pop, sp_wr, stack_limit_register_wr;
  logic [3:0] x_ptr, y_ptr;
  logic [15:0] x_ea, x_wdata, wreg_old, y_ea, y_mod_start, y_mod_end, pm_ptr, pm_br_mod;
  logic [15:0] push_data, sp_wdata, stack_limit_register_wdata, mx_rd, my_rd, mx_wd;
  logic [15:0] x_rdata, wreg_new, y_rdata, y_ptr_next, pm_ptr_next, sp_out;
  logic [7:0] status_low_byte;
  dsau_push_t push_kind;
  logic [14:0] mx_addr, my_addr, e_ad;
  logic [1:0] mx_we, e_we;
  logic mx_re, my_re, x_rvalid, y_rvalid, addr_trap, stack_trap;
  // bench reference state
  logic [15:0] ref_mem [0:1279];
  logic [15:0] sp, lim, ea, wd, e_xd, e_wr, e_yd, e_yp, e_pm, e_pw;
  logic e_xv, e_yv, e_at, e_st, c_rv, c_x, c_w, c_yp, c_pm, yok, lo, hi;
  integer seed = 17562;
  integer miscompares = 0;
  integer checks = 0;
  integer cyc = 0;
  integer r, r2, k, kd;

  dsau_top i_dut (.I_CLK_SYS(clk), .I_RST(rst), .I_X_REQ(x_req), .I_X_WR(x_wr),
    .I_X_BYTE(x_byte), .I_X_NEAR(x_near), .I_X_ACC_WB(acc_wb), .I_MAC(mac), .I_X_PTR(x_ptr),
    .I_X_EA(x_ea), .I_X_WDATA(x_wdata), .I_WREG_OLD(wreg_old), .I_Y_REQ(y_req),
    .I_Y_PTR(y_ptr), .I_Y_EA(y_ea), .I_Y_MOD_EN(y_mod_en), .I_Y_MOD_START(y_mod_start),
    .I_Y_MOD_END(y_mod_end), .I_PM_PTR(pm_ptr), .I_PM_BYTE(pm_byte), .I_PM_BITREV(pm_bitrev),
    .I_PM_WRITE(pm_write), .I_PM_BR_MOD(pm_br_mod), .I_SP_PUSH(sp_push), .I_SP_POP(sp_pop),
    .I_PUSH_KIND(push_kind), .I_PUSH_DATA(push_data), .I_SRL(status_low_byte), .I_SP_WR(sp_wr),
    .I_SP_WDATA(sp_wdata), .I_STACK_LIMIT_REGISTER_WR(stack_limit_register_wr), .I_STACK_LIMIT_REGISTER_WDATA(stack_limit_register_wdata),
    .O_MEM_X_ADDR(mx_addr), .O_MEM_X_RE(mx_re), .O_MEM_X_WE(mx_we), .O_MEM_X_WDATA(mx_wd),
    .I_MEM_X_RDATA(mx_rd), .O_MEM_Y_ADDR(my_addr), .O_MEM_Y_RE(my_re),
    .I_MEM_Y_RDATA(my_rd), .O_X_RDATA(x_rdata), .O_X_RVALID(x_rvalid),
    .O_WREG_NEW(wreg_new), .O_Y_RDATA(y_rdata), .O_Y_RVALID(y_rvalid),
    .O_Y_PTR_NEXT(y_ptr_next), .O_PM_PTR_NEXT(pm_ptr_next), .O_SP(sp_out),
    .O_ADDR_ERR_TRAP(addr_trap), .O_STACK_ERR_TRAP(stack_trap));

  dsau_mem_model i_mem (.i_clk(clk), .i_x_addr(mx_addr), .i_x_re(mx_re), .i_x_we(mx_we),
    .i_x_wdata(mx_wd), .o_x_rdata(mx_rd), .i_y_addr(my_addr), .i_y_re(my_re),
    .o_y_rdata(my_rd));

  // free running system clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task close_out;
    if (miscompares == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  function automatic logic [15:0] rev(input logic [15:0] v);
    for (int b = 0; b < 16; b++) rev[b] = v[15 - b];
  endfunction

  // hang guard, well above the 3010 cycles the run needs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 4000)
    begin
      miscompares++;
      close_out();
    end
  end

  // random traffic on every port, checked against the reference each cycle
  initial
  begin
    {x_req, x_wr, x_byte, x_near, acc_wb, mac, y_req, y_mod_en, pm_byte, pm_bitrev} = '0;
    {pm_write, sp_push, sp_pop, sp_wr, stack_limit_register_wr, x_ptr, y_ptr, status_low_byte} = '0;
    {x_ea, x_wdata, wreg_old, y_ea, y_mod_start, y_mod_end, pm_ptr, pm_br_mod} = '0;
    {push_data, sp_wdata, stack_limit_register_wdata} = '0;
    push_kind = DSAU_PUSH_DATA;
    rst = 1'b1;
    for (int i = 0; i < 1280; i++) ref_mem[i] = 16'(i) * 16'h0123 ^ 16'h5A5A;
    sp = 16'h0800;
    {e_xv, e_yv, e_at, e_st, c_rv, c_x, c_w, c_yp, c_pm} = '0;
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    for (k = 0; k < 3000; k++)
    begin
      @(posedge clk);
      #1;
      chk("sp", sp_out, sp);
      chk("stack_trap", stack_trap, e_st);
      chk("addr_trap", addr_trap, e_at);
      chk("y_rvalid", y_rvalid, e_yv);
      if (c_rv) chk("x_rvalid", x_rvalid, e_xv);
      if (c_x) chk("x_rdata", x_rdata, e_xd);
      if (c_w) chk("wreg_new", wreg_new, e_wr);
      if (e_yv) chk("y_rdata", y_rdata, e_yd);
      if (c_yp) chk("y_ptr_next", y_ptr_next, e_yp);
      if (c_pm) chk("pm_ptr_next", pm_ptr_next, e_pm);
      r = $random(seed);
      r2 = $random(seed);
      kd = (k == 0) ? 6 : r[2:0];
      // keep the stack inside implemented memory, crossing the low guard
      if (kd == 3 && sp >= 16'h09F0) kd = 4;
      if (kd == 4 && sp < 16'h07F8) kd = 3;
      x_req = kd < 3 || kd == 7;
      x_wr = kd == 2;
      {x_byte, x_near, acc_wb} = r[5:3];
      mac = r[6] || kd == 7;
      x_ptr = r[8] ? r[12:9] : {3'b100, r[9]};
      x_ea = 16'h0700 + {6'h00, r2[9:0]};
      if (x_near) x_ea = x_ea | {r2[12:10], 13'h0000};
      {x_wdata, wreg_old} = {r2[31:16], r[31:16]};
      sp_push = kd == 3;
      sp_pop = kd == 4;
      push_kind = dsau_push_t'(3'b001 << (r[10:9] % 3));
      {push_data, status_low_byte} = {r2[31:16], r[23:16]};
      sp_wr = kd == 6 && r[11];
      stack_limit_register_wr = kd == 6;
      sp_wdata = 16'h0800 + {8'h00, r2[7:0]};
      stack_limit_register_wdata = 16'h0800 + {7'h00, r2[15:8], r[13]};
      y_req = r[14];
      y_ptr = r[15] ? r[27:24] : {3'b101, r[24]};
      y_ea = 16'h08C0 + {7'h00, r2[20:13], 1'b0};
      {y_mod_en, y_mod_start} = {r[25], 16'h0900};
      y_mod_end = r[26] ? y_ea : 16'h09FE;
      {pm_ptr, pm_br_mod} = {r[31:24], r2[23:16], r2[7:0], r[23:16]};
      {pm_byte, pm_bitrev, pm_write} = r[29:27];
      // reference: y prefetch first, it sees memory before this cycle's write
      e_yv = y_req && mac;
      c_yp = e_yv && y_ptr[3:1] == 3'b101;
      yok = c_yp && y_ea >= 16'h0900 && y_ea < 16'h0A00;
      e_yd = yok ? ref_mem[y_ea[15:1]] : 16'h0000;
      e_yp = (y_mod_en && y_ea == y_mod_end) ? y_mod_start : y_ea + 16'h0002;
      ea = x_near ? {3'b000, x_ea[12:0]} : x_ea;
      e_xv = (x_req && !x_wr) || sp_pop;
      c_rv = !(kd == 2 || kd == 3);
      c_x = e_xv;
      c_w = x_req && !x_wr;
      e_at = x_req && !x_byte && ea[0];
      e_ad = ea[15:1];
      wd = (ea < 16'h0A00 && !(mac && !acc_wb && (x_ptr[3:1] != 3'b100 || ea >= 16'h0900)))
        ? ref_mem[ea[15:1]] : 16'h0000;
      e_xd = x_byte ? {8'h00, ea[0] ? wd[15:8] : wd[7:0]} : wd;
      e_wr = x_byte ? {wreg_old[15:8], e_xd[7:0]} : wd;
      lo = !x_byte || !ea[0];
      hi = !x_byte || ea[0];
      e_we = (x_req && x_wr && ea < 16'h0A00 && !e_at) ? {hi, lo} : 2'b00;
      if (e_we[0]) ref_mem[ea[15:1]][7:0] = x_wdata[7:0];
      if (e_we[1]) ref_mem[ea[15:1]][15:8] = x_byte ? x_wdata[7:0] : x_wdata[15:8];
      e_st = 1'b0;
      if (sp_push)
      begin
        {e_we, e_ad} = {2'b11, sp[15:1]};
        e_st = sp > lim || sp < 16'h0800;
        e_pw = push_kind == DSAU_PUSH_DATA ? push_data
          : {push_kind == DSAU_PUSH_EXC ? status_low_byte : 8'h00, push_data[7:0]};
        ref_mem[sp[15:1]] = e_pw;
        sp = sp + 16'h0002;
      end
      if (sp_pop)
      begin
        sp = sp - 16'h0002;
        e_st = sp < 16'h0800;
        {e_ad, e_xd} = {sp[15:1], ref_mem[sp[15:1]]};
      end
      if (sp_wr) sp = sp_wdata & 16'hFFFE;
      if (stack_limit_register_wr) lim = stack_limit_register_wdata & 16'hFFFE;
      c_pm = 1'b1;
      e_pm = (pm_bitrev && pm_write) ? rev(rev(pm_ptr) + rev(pm_br_mod))
        : pm_ptr + (pm_byte ? 16'h0001 : 16'h0002);
      // memory side strobes settle within the cycle
      #1;
      chk("mem_x_we", 16'(mx_we), 16'(e_we));
      chk("mem_y_re", 16'(my_re), 16'(yok));
      if (x_req || sp_push || sp_pop) chk("mem_x_addr", 16'(mx_addr), 16'(e_ad));
      if (yok) chk("mem_y_addr", 16'(my_addr), 16'(y_ea[15:1]));
      if (sp_push) chk("mem_x_wdata", mx_wd, e_pw);
    end
    close_out();
  end
endmodule
